// ===== core/dctp_protect.sv
// Drive current and thermal protection supervisor with APB registers
//
// Contract
// - Every current command is saturated at the command limit.
// - Measured current above 1.6 times IGBT maximum raises E212.
// - Heatsink at its limit raises E106 and a torqueless stop.
// - A warning rises within 5 degC below the heatsink limit.
// - Heatsink reading in 0.1 degC is readable, clamped 0..110.
// - The heatsink fault limit is readable alongside the reading.
// - Squared current is integrated over a window as an rms estimate.
// - The i2t estimate above its limit raises overload E202.
// - Allowed rms is 0.5 IGBT max (sync) or motor value (async).
// - The i2t limit rescales with the PWM frequency selection.
`timescale 1ns/10ps
module dctp_protect (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Current path
	input  wire logic [15:0] cmd_in,
	output logic      [15:0] cmd_out,
	input  wire logic [15:0] i_meas,
	// Heatsink sensor pins
	input  wire logic [11:0] sink_temp_pin,
	// Outputs to power stage and system
	output logic             torqueless_stop,
	output logic             warn,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////
	// Registers

	localparam int CW = dctp_pkg::CUR_W;
	localparam int TW = dctp_pkg::TEMP_W;
	localparam int AW = dctp_pkg::ACC_W;
	localparam int NE = dctp_pkg::NUM_EVENTS;

	logic          ctrl_async;
	logic [NE-1:0] status;
	logic [NE-1:0] mask;
	logic [NE-1:0] faults;
	logic [CW-1:0] cmd_limit;
	logic [CW-1:0] igbt_max;
	logic [TW-1:0] temp_lim;
	logic [CW-1:0] rms_asyn;
	logic [1:0]    pwm_sel;
	logic [TW-1:0] temp_raw;
	logic [TW-1:0] temp_val;
	logic [AW-1:0] acc;
	logic          i2t_over;

	////////////////////////////////////////////////////////////////////
	// Bus decode

	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	wire mapped = hit(paddr, dctp_pkg::OFS_CTRL)
		|| hit(paddr, dctp_pkg::OFS_STATUS)
		|| hit(paddr, dctp_pkg::OFS_MASK)
		|| hit(paddr, dctp_pkg::OFS_CMD_LIMIT)
		|| hit(paddr, dctp_pkg::OFS_IGBT_MAX)
		|| hit(paddr, dctp_pkg::OFS_TEMP)
		|| hit(paddr, dctp_pkg::OFS_TEMP_LIM)
		|| hit(paddr, dctp_pkg::OFS_RMS_SYNC)
		|| hit(paddr, dctp_pkg::OFS_RMS_ASYN)
		|| hit(paddr, dctp_pkg::OFS_I2T_ACC)
		|| hit(paddr, dctp_pkg::OFS_FAULTS)
		|| hit(paddr, dctp_pkg::OFS_PWM_SEL);

	// Zero wait states; unmapped access answers with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	wire clr_faults = wr_en && hit(paddr, dctp_pkg::OFS_CTRL)
		&& pwdata[dctp_pkg::CTRL_CLR_BIT];
	wire rd_status  = rd_en && hit(paddr, dctp_pkg::OFS_STATUS);

	////////////////////////////////////////////////////////////////////
	// Heatsink sensor

	dctp_sync #(.W(TW)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (sink_temp_pin),
		.dout    (temp_raw)
	);

	// Out-of-range readings clamp at the top of the valid range
	assign temp_val = (temp_raw > dctp_pkg::TEMP_MAX)
		? dctp_pkg::TEMP_MAX : temp_raw;

	wire [TW:0] warn_base = {1'b0, temp_lim} - {1'b0, dctp_pkg::WARN_MARGIN};
	wire over_temp = temp_val >= temp_lim;
	wire warn_cond = warn_base[TW] || ({1'b0, temp_val} >= warn_base);

	////////////////////////////////////////////////////////////////////
	// Current checks

	wire [CW-1:0] i_abs = i_meas[CW-1] ? CW'(-i_meas) : i_meas;
	wire [CW+3:0] oc_lhs = i_abs * dctp_pkg::OC_DEN;
	wire [CW+3:0] oc_rhs = igbt_max * dctp_pkg::OC_NUM;
	wire over_cur = oc_lhs > oc_rhs;

	wire [CW-1:0] c_abs = cmd_in[CW-1] ? CW'(-cmd_in) : cmd_in;
	wire [CW-1:0] c_sat = (c_abs > cmd_limit) ? cmd_limit : c_abs;
	wire [CW-1:0] cmd_next = cmd_in[CW-1] ? CW'(-c_sat) : c_sat;

	// Limit is software's job to keep below the peak current

	////////////////////////////////////////////////////////////////////
	// i2t overload

	wire [CW-1:0] rms_sync = igbt_max >> 1;
	wire [CW-1:0] rms_allow = ctrl_async ? rms_asyn : rms_sync;

	logic [3:0] scale;
	always_comb begin
		unique case (pwm_sel)
			2'h0: scale = dctp_pkg::PWM_SCALE_0;
			2'h1: scale = dctp_pkg::PWM_SCALE_1;
			2'h2: scale = dctp_pkg::PWM_SCALE_2;
			2'h3: scale = dctp_pkg::PWM_SCALE_3;
		endcase
	end

	// Steady accumulator value for rms_allow is rms_allow squared
	wire [AW-1:0] base_lim = rms_allow * rms_allow;
	wire [AW+3:0] scaled = base_lim * scale;
	wire [AW-1:0] i2t_lim = scaled[AW+dctp_pkg::SCALE_SHIFT-1:
		dctp_pkg::SCALE_SHIFT];

	dctp_i2t u_i2t (
		.pclk    (pclk),
		.presetn (presetn),
		.i_abs   (i_abs),
		.limit   (i2t_lim),
		.acc     (acc),
		.over    (i2t_over)
	);

	////////////////////////////////////////////////////////////////////
	// Events, faults and interrupt

	wire [NE-1:0] ev;
	assign ev[dctp_pkg::ST_OVERCUR]  = over_cur;
	assign ev[dctp_pkg::ST_OVERTEMP] = over_temp;
	assign ev[dctp_pkg::ST_WARN]     = warn_cond;
	assign ev[dctp_pkg::ST_OVERLOAD] = i2t_over;

	wire [NE-1:0] next_status = ev | (rd_status ? '0 : status);
	// Warning follows the temperature; only real faults latch
	wire [NE-1:0] fault_ev = ev & ~(NE'(1) << dctp_pkg::ST_WARN);
	wire [NE-1:0] next_faults = fault_ev | (clr_faults ? '0 : faults);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
			faults <= '0;
		end else begin
			status <= next_status;
			faults <= next_faults;
		end
	end

	assign irq = |(status & mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_out         <= '0;
			torqueless_stop <= 1'b0;
			warn            <= 1'b0;
		end else begin
			cmd_out         <= cmd_next;
			torqueless_stop <= next_faults[dctp_pkg::ST_OVERTEMP];
			warn            <= warn_cond;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_async <= 1'b0;
			mask       <= '0;
			cmd_limit  <= dctp_pkg::CMD_LIMIT_RST;
			igbt_max   <= dctp_pkg::IGBT_MAX_RST;
			temp_lim   <= dctp_pkg::TEMP_LIM_RST;
			rms_asyn   <= dctp_pkg::RMS_ASYN_RST;
			pwm_sel    <= '0;
		end else if (wr_en) begin
			if (hit(paddr, dctp_pkg::OFS_CTRL))
				ctrl_async <= pwdata[dctp_pkg::CTRL_ASYNC_BIT];
			if (hit(paddr, dctp_pkg::OFS_MASK))
				mask <= pwdata[NE-1:0];
			if (hit(paddr, dctp_pkg::OFS_CMD_LIMIT))
				cmd_limit <= pwdata[CW-1:0];
			if (hit(paddr, dctp_pkg::OFS_IGBT_MAX))
				igbt_max <= pwdata[CW-1:0];
			if (hit(paddr, dctp_pkg::OFS_TEMP_LIM))
				temp_lim <= pwdata[TW-1:0];
			if (hit(paddr, dctp_pkg::OFS_RMS_ASYN))
				rms_asyn <= pwdata[CW-1:0];
			if (hit(paddr, dctp_pkg::OFS_PWM_SEL))
				pwm_sel <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux

	logic [31:0] rdata;
	always_comb begin
		rdata = '0;
		unique case (1'b1)
			hit(paddr, dctp_pkg::OFS_CTRL):
				rdata[dctp_pkg::CTRL_ASYNC_BIT] = ctrl_async;
			hit(paddr, dctp_pkg::OFS_STATUS):    rdata[NE-1:0] = status;
			hit(paddr, dctp_pkg::OFS_MASK):      rdata[NE-1:0] = mask;
			hit(paddr, dctp_pkg::OFS_CMD_LIMIT): rdata[CW-1:0] = cmd_limit;
			hit(paddr, dctp_pkg::OFS_IGBT_MAX):  rdata[CW-1:0] = igbt_max;
			hit(paddr, dctp_pkg::OFS_TEMP):
				rdata[TW-1:0] = temp_val;
			hit(paddr, dctp_pkg::OFS_TEMP_LIM):
				rdata[TW-1:0] = temp_lim;
			hit(paddr, dctp_pkg::OFS_RMS_SYNC):  rdata[CW-1:0] = rms_sync;
			hit(paddr, dctp_pkg::OFS_RMS_ASYN):  rdata[CW-1:0] = rms_asyn;
			hit(paddr, dctp_pkg::OFS_I2T_ACC):   rdata = acc;
			hit(paddr, dctp_pkg::OFS_FAULTS):    rdata[NE-1:0] = faults;
			hit(paddr, dctp_pkg::OFS_PWM_SEL):   rdata[1:0] = pwm_sel;
			default:                             rdata = '0;
		endcase
	end

	// Read data registered on the setup cycle so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= rdata;
	end

endmodule

// ===== shared/dctp_pkg.sv
// Package: register map, field layout and constants of the drive protector
package dctp_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_MASK      = 8'h08;
	localparam logic [7:0] OFS_CMD_LIMIT = 8'h0c;
	localparam logic [7:0] OFS_IGBT_MAX  = 8'h10;
	localparam logic [7:0] OFS_TEMP      = 8'h14;
	localparam logic [7:0] OFS_TEMP_LIM  = 8'h18;
	localparam logic [7:0] OFS_RMS_SYNC  = 8'h1c;
	localparam logic [7:0] OFS_RMS_ASYN  = 8'h20;
	localparam logic [7:0] OFS_I2T_ACC   = 8'h24;
	localparam logic [7:0] OFS_FAULTS    = 8'h28;
	localparam logic [7:0] OFS_PWM_SEL   = 8'h2c;

	// Control register fields
	localparam int CTRL_ASYNC_BIT = 0;
	localparam int CTRL_CLR_BIT   = 1;

	// Status / mask / fault bit positions
	localparam int ST_OVERCUR  = 0;
	localparam int ST_OVERTEMP = 1;
	localparam int ST_WARN     = 2;
	localparam int ST_OVERLOAD = 3;
	localparam int NUM_EVENTS  = 4;

	// Widths
	localparam int CUR_W  = 16;
	localparam int TEMP_W = 12;
	localparam int ACC_W  = 32;
	localparam int PWM_W  = 2;

	// Temperature in 0.1 degC units: valid 0..110 degC
	localparam logic [TEMP_W-1:0] TEMP_MAX     = 12'h44c;
	localparam logic [TEMP_W-1:0] WARN_MARGIN  = 12'h032;

	// Reset values
	localparam logic [CUR_W-1:0]  CMD_LIMIT_RST = 16'h0100;
	localparam logic [CUR_W-1:0]  IGBT_MAX_RST  = 16'h0200;
	localparam logic [TEMP_W-1:0] TEMP_LIM_RST  = 12'h320;
	localparam logic [CUR_W-1:0]  RMS_ASYN_RST  = 16'h0100;

	// Window length of the moving i2t average, as a power of two
	localparam int WIN_SHIFT = 8;

	// Switching-loss scaling of the i2t limit, numerator over 8
	localparam logic [3:0] PWM_SCALE_0 = 4'h8;
	localparam logic [3:0] PWM_SCALE_1 = 4'h7;
	localparam logic [3:0] PWM_SCALE_2 = 4'h6;
	localparam logic [3:0] PWM_SCALE_3 = 4'h5;
	localparam int SCALE_SHIFT = 3;

	// Overcurrent trip factor 1.6 = 8/5
	localparam logic [3:0] OC_NUM = 4'h8;
	localparam logic [3:0] OC_DEN = 4'h5;

	// Fault codes shown to software
	localparam logic [11:0] CODE_OVERCUR  = 12'h212;
	localparam logic [11:0] CODE_OVERTEMP = 12'h106;
	localparam logic [11:0] CODE_OVERLOAD = 12'h202;

	// Parameter identifiers, values arbitrary
	localparam logic [15:0] COMMAND_LIMIT_PARAM_ID = 16'h0a01;
	localparam logic [15:0] SINK_TEMP_PARAM_ID     = 16'h0a02;
	localparam logic [15:0] SINK_LIMIT_PARAM_ID    = 16'h0a03;

endpackage

// ===== core/dctp_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module dctp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// ===== core/dctp_i2t.sv
// Leaky-integrator i2t estimator with overload compare
`timescale 1ns/10ps
module dctp_i2t (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// Current sample and limit
	input  wire logic [dctp_pkg::CUR_W-1:0]   i_abs,
	input  wire logic [dctp_pkg::ACC_W-1:0]   limit,
	// Estimate and trip
	output logic      [dctp_pkg::ACC_W-1:0]   acc,
	output logic                              over
);

	logic [dctp_pkg::ACC_W-1:0] sq;
	logic [dctp_pkg::ACC_W-1:0] leak;
	logic [dctp_pkg::ACC_W:0]   sum;

	// Leaky integrator stands in for a moving window: no sample store
	assign sq   = i_abs * i_abs;
	assign leak = acc >> dctp_pkg::WIN_SHIFT;
	assign sum  = {1'b0, acc} - {1'b0, leak}
		+ {{(dctp_pkg::WIN_SHIFT+1){1'b0}},
		sq[dctp_pkg::ACC_W-1:dctp_pkg::WIN_SHIFT]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc  <= '0;
			over <= 1'b0;
		end else begin
			acc  <= sum[dctp_pkg::ACC_W] ? '1 : sum[dctp_pkg::ACC_W-1:0];
			over <= acc > limit;
		end
	end

endmodule

// ===== test/dctp_protect_assertions.sv
// Port-level checker for the drive protector, bound to its top module
`timescale 1ns/10ps
module dctp_chk (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Current path and sensor
	input wire logic [15:0] cmd_in,
	input wire logic [15:0] cmd_out,
	input wire logic [15:0] i_meas,
	input wire logic [11:0] sink_temp_pin,
	// Outputs
	input wire logic        torqueless_stop,
	input wire logic        warn,
	input wire logic        irq
);
	logic [15:0] lim;
	logic [15:0] igbt;
	logic [11:0] tlim;
	logic [3:0]  msk;
	logic [1:0]  up;
	wire         wr = psel && penable && pwrite;
	wire         clr = wr && paddr == 8'h00 && pwdata[1];
	wire  [15:0] ia = i_meas[15] ? -i_meas : i_meas;
	wire         oc = 19'(ia) * 19'h5 > {igbt, 3'h0};
	wire         bad = paddr > 8'h2c || paddr[1:0] != 2'h0;

	function automatic logic [15:0] sat(input logic [15:0] c, l);
		if ($signed(c) > $signed(l))
			return l;
		if ($signed(c) < -$signed(l))
			return -l;
		return c;
	endfunction

	// Mask shadow starts all-ones: a_irq_masked judges irq only after a write, a_oc_irq from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim  <= dctp_pkg::CMD_LIMIT_RST;
			igbt <= dctp_pkg::IGBT_MAX_RST;
			tlim <= dctp_pkg::TEMP_LIM_RST;
			msk  <= 4'hf;
			up   <= 2'h0;
		end else begin
			up <= up == 2'h3 ? up : up + 2'h1;
			if (wr && paddr == 8'h0c)
				lim <= pwdata[15:0];
			if (wr && paddr == 8'h10)
				igbt <= pwdata[15:0];
			if (wr && paddr == 8'h18)
				tlim <= pwdata[11:0];
			if (wr && paddr == 8'h08)
				msk <= pwdata[3:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_cmd_sat: assert property (up == 2'h3 |->
		cmd_out == sat($past(cmd_in), $past(lim)))
		else $error("Command not saturated at limit");
	a_oc_irq: assert property (oc && msk[0] |=> irq)
		else $error("Overcurrent did not raise irq");
	a_temp_stop: assert property (
		(sink_temp_pin >= tlim && $stable(tlim))[*4] |-> torqueless_stop)
		else $error("Over-temperature gave no stop");
	a_stop_latched: assert property (
		torqueless_stop && !clr |=> torqueless_stop)
		else $error("Stop released without clear");
	a_warn_level: assert property (
		($stable(sink_temp_pin) && $stable(tlim))[*3] |->
		warn == (sink_temp_pin >= tlim - dctp_pkg::WARN_MARGIN))
		else $error("Warning level wrong");
	a_slverr_map: assert property (psel && penable |-> pslverr == bad)
		else $error("Slave error does not match address map");
	a_pready_high: assert property (psel && penable |-> pready)
		else $error("Access not answered");
	a_irq_masked: assert property (msk == 4'h0 |-> !irq)
		else $error("Irq with all events masked");

	c_stop: cover property ($rose(torqueless_stop));
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (psel && penable && pslverr);
endmodule

bind dctp_protect dctp_chk i_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_in,
	.cmd_out, .i_meas, .sink_temp_pin, .torqueless_stop, .warn, .irq);

// ===== test/dctp_stage_model.sv
// Behavioural power stage: current feedback and heatsink sensor
`timescale 1ns/10ps
module dctp_stage_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Regulated command and test controls
	input  wire logic [15:0] cmd_out,
	input  wire logic [15:0] inj,
	input  wire logic [11:0] temp,
	// Sensed values
	output logic      [15:0] i_meas,
	output logic      [11:0] sink_temp_pin
);
	// Current follows the command; nonzero inj models a fault current
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i_meas        <= 16'h0;
			sink_temp_pin <= 12'h0;
		end else begin
			i_meas        <= inj != 16'h0 ? inj : cmd_out;
			sink_temp_pin <= temp;
		end
	end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the drive protector
`timescale 1ns/10ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        torqueless_stop, warn, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] cmd_in, cmd_out, i_meas, inj;
	logic [11:0] sink_temp_pin, temp;
	logic [39:0] exp_q[$];
	int          mismatches, n_checks;

	dctp_protect i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmd_in, .cmd_out, .i_meas,
		.sink_temp_pin, .torqueless_stop, .warn, .irq);
	dctp_stage_model i_stage (.pclk, .presetn, .cmd_out, .inj, .temp,
		.i_meas, .sink_temp_pin);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic complete_run();
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Reads note their expectation; the monitor below judges it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		if (!w)
			exp_q.push_back({a, d});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmp_reg(input logic [7:0] a, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] reg %h exp %h got %h", a, e, g);
		end
	endtask

	// Level outputs are judged mid-cycle, where they are settled
	task automatic cmp_pin(input string n, input logic e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %b got %b", n, e, g);
		end
	endtask

	always @(posedge pclk)
		if (psel && penable && !pwrite && pready === 1'b1) begin
			cmp_reg(exp_q[0][39:32], exp_q[0][31:0], prdata);
			void'(exp_q.pop_front());
		end

	always @(posedge pclk)
		cmd_in <= 16'($urandom);

	initial begin
		#100us;
		mismatches++;
		complete_run();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, cmd_in, inj, temp} = '0;
		presetn = 1'b0;
		mismatches = 0;
		n_checks = 0;
		void'($urandom(32'hbef0690f));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h0c, 32'(dctp_pkg::CMD_LIMIT_RST));
		apb(0, 8'h18, 32'(dctp_pkg::TEMP_LIM_RST));
		apb(0, 8'h1c, 32'(dctp_pkg::IGBT_MAX_RST >> 1));
		apb(0, 8'h30, 32'h0);
		apb(1, 8'h0c, 32'h40);
		repeat (50) @(posedge pclk);
		apb(0, 8'h0c, 32'h40);
		// Negative currents just under and just over the trip point
		apb(1, 8'h08, 32'hf);
		inj <= 16'hfccd;
		repeat (3) @(posedge pclk);
		apb(0, 8'h04, 32'h0);
		inj <= 16'hfccc;
		repeat (2) @(posedge pclk);
		inj <= 16'h0;
		@(negedge pclk);
		cmp_pin("irq", 1'b1, irq);
		apb(0, 8'h28, 32'h1);
		apb(0, 8'h04, 32'h1);
		apb(0, 8'h04, 32'h0);
		apb(1, 8'h00, 32'h2);
		apb(0, 8'h28, 32'h0);
		apb(1, 8'h08, 32'h0);
		temp <= 12'h2ed;
		repeat (5) @(posedge pclk);
		apb(0, 8'h04, 32'h0);
		temp <= 12'h2ee;
		repeat (5) @(posedge pclk);
		apb(0, 8'h04, 32'h4);
		temp <= 12'h320;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		cmp_pin("torqueless_stop", 1'b1, torqueless_stop);
		cmp_pin("warn", 1'b1, warn);
		apb(0, 8'h28, 32'h2);
		apb(0, 8'h14, 32'h320);
		temp <= 12'h500;
		repeat (5) @(posedge pclk);
		apb(0, 8'h14, 32'(dctp_pkg::TEMP_MAX));
		temp <= 12'h0;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		cmp_pin("warn", 1'b0, warn);
		cmp_pin("torqueless_stop", 1'b1, torqueless_stop);
		apb(0, 8'h04, 32'h6);
		apb(1, 8'h00, 32'h2);
		apb(0, 8'h28, 32'h0);
		@(negedge pclk);
		cmp_pin("torqueless_stop", 1'b0, torqueless_stop);
		apb(0, 8'h04, 32'h0);
		// Steady i2t sits between the 6/8 and 7/8 scaled limits
		inj <= 16'he0;
		repeat (3000) @(posedge pclk);
		apb(0, 8'h24, 32'hc400);
		for (int s = 0; s < 4; s++) begin
			apb(1, 8'h2c, 32'(s));
			repeat (4) @(posedge pclk);
			apb(0, 8'h28, s > 1 ? 32'h8 : 32'h0);
		end
		apb(1, 8'h2c, 32'h0);
		inj <= 16'h0;
		repeat (4) @(posedge pclk);
		apb(1, 8'h00, 32'h2);
		apb(0, 8'h28, 32'h0);
		complete_run();
	end
endmodule
